// [tb/apdc_host_model.sv]
// Host bus model: address strobe pulses and a free-running logic clock.
`timescale 1ns/1ps
module apdc_host_model
(
  input wire logic clk,
  input wire logic reset,
  input wire logic strobe_run,
  output logic strobe_pin,
  output logic clock_pin
);
  logic [1:0] div_q;

  // The logic clock keeps running while the host sleeps, so idle time is
  // still measured when the strobe has stopped.
  always @(negedge clk or posedge reset)
  begin
    if (reset)
    begin
      div_q <= 2'h0;
      strobe_pin <= 1'b0;
      clock_pin <= 1'b0;
    end
    else
    begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3)
      begin
        clock_pin <= ~clock_pin;
        if (strobe_run)
        begin
          strobe_pin <= ~strobe_pin;
        end
      end
    end
  end
endmodule

// [tb/tb.sv]
// Self-checking bench for the automatic power-down control block.
`timescale 1ns/1ps
module tb import apdc_pkg::*;
;
  logic clk, reset, cs_pin, rst_n, run, awr, cwr, seen_f, leak, cfg;
  logic [7:0] wdata, hdata, d, e, rega, regc, adata;
  logic [15:0] haddr, aaddr;
  logic [4:0] ctl, a, b, blk, lctl;
  logic [2:0] oe;
  logic pd, aclk, mclk, turbo, lstb, strobe, lclk;
  logic [3:0] icnt;
  apdc_mem_t msel, mstb;
  apdc_pin_ctl_t pctl;
  int miscompares, samples_checked;
  integer seed = 32'h3399723c;

  apdc_host_model host (.clk(clk), .reset(reset), .strobe_run(run),
    .strobe_pin(strobe), .clock_pin(lclk));

  apdc_top uut (.clk(clk), .reset(reset), .port_d_pin0(strobe),
    .port_d_pin1(lclk), .port_d_pin2(cs_pin), .reset_pin_n(rst_n),
    .cfg_strobe_pin(cfg), .cfg_clock_pin(cfg), .cfg_cs_pin(cfg),
    .reg_a_wr(awr), .reg_c_wr(cwr), .reg_wdata(wdata), .host_addr(haddr),
    .host_data(hdata), .ctl_in(ctl), .data_port_oe_req(oe[2]),
    .periph_oe_req(oe[1]), .addr_out_req(oe[0]),
    .power_mode_reg_a_q(rega), .power_mode_reg_c_q(regc),
    .power_down_signal_q(pd), .idle_count_q(icnt), .arr_addr_q(aaddr),
    .arr_data_q(adata), .mem_sel_q(msel), .mem_standby_q(mstb),
    .pin_ctl_q(pctl), .logic_ctl_q(lctl), .array_clk_q(aclk),
    .mcell_clk_q(mclk), .logic_turbo_q(turbo), .logic_standby_q(lstb));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Registers keep only their defined bits; unused bits read as zero.
  function automatic logic [7:0] exp_reg(input logic [7:0] v,
    input logic [7:0] mask);
    return v & mask;
  endfunction

  // A blocked control input keeps the level it had before the block.
  function automatic logic [4:0] exp_ctl(input logic [4:0] held,
    input logic [4:0] fresh, input logic [4:0] blk);
    return (held & blk) | (fresh & ~blk);
  endfunction

  task automatic wr(input logic to_a, input logic [7:0] v);
    @(negedge clk);
    awr = to_a;
    cwr = !to_a;
    wdata = v;
    @(negedge clk);
    awr = 1'b0;
    cwr = 1'b0;
    @(negedge clk);
  endtask

  task automatic wait_pd(input logic lvl, input int lim);
    int n;
    n = 0;
    seen_f = 1'b0;
    leak = 1'b0;
    while (pd !== lvl && n < lim)
    begin
      @(negedge clk);
      seen_f = seen_f | (icnt === 4'hf);
      leak = leak | (aclk !== 1'b0) | (mclk !== 1'b0);
      n++;
    end
    chk(16'(pd), 16'(lvl));
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    {cs_pin, awr, cwr, wdata, hdata, haddr, ctl} = '0;
    {cfg, rst_n, run, oe, reset} = '1;
    miscompares = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    chk(16'(rega), 16'h0);
    chk(16'(regc), 16'h0);
    chk(16'(turbo), 16'h1);
    chk(16'(pd), 16'h0);
    $display("reset values done");
    repeat (8)
    begin
      d = 8'($random(seed));
      e = 8'($random(seed));
      wr(1'b1, d);
      chk(16'(rega), 16'(exp_reg(d, REG_A_USED_MASK)));
      wr(1'b0, e);
      chk(16'(regc), 16'(exp_reg(e, REG_C_USED_MASK)));
    end
    wr(1'b1, 8'h18);
    chk(16'(turbo), 16'h0);
    @(negedge clk);
    chk(16'(lstb), 16'h1);
    hdata = 8'($random(seed)) | 8'h01;
    @(negedge clk);
    chk(16'(lstb), 16'h0);
    chk(16'(mstb), 16'h0);
    chk(16'(adata), 16'(hdata));
    $display("register writes done");
    wr(1'b0, 8'h00);
    repeat (8)
    begin
      wr(1'b0, 8'h00);
      a = 5'($random(seed));
      ctl = a;
      repeat (3) @(negedge clk);
      chk(16'(lctl), 16'(a));
      d = 8'($random(seed));
      blk = d[6:2];
      wr(1'b0, d);
      b = 5'($random(seed));
      ctl = b;
      repeat (3) @(negedge clk);
      chk(16'(lctl), 16'(exp_ctl(a, b, blk)));
    end
    wr(1'b0, 8'h00);
    $display("input blocking done");
    wr(1'b1, 8'h00);
    run = 1'b0;
    repeat (200) @(negedge clk);
    chk(16'(pd), 16'h0);
    chk(16'(icnt), 16'h0);
    chk(16'(mstb), 16'hf);
    wr(1'b1, 8'h32);
    wait_pd(1'b1, 600);
    chk(16'(seen_f), 16'h1);
    chk(16'(leak), 16'h0);
    chk(16'(msel), 16'h0);
    chk(16'(mstb), 16'hf);
    chk(16'(pctl), 16'h0);
    haddr = ~haddr;
    ctl = 5'($random(seed));
    repeat (4) @(negedge clk);
    chk(16'(icnt), 16'h0);
    chk(16'(aaddr === haddr), 16'h0);
    chk(16'(lctl), 16'(ctl));
    run = 1'b1;
    wait_pd(1'b0, 40);
    repeat (4) @(negedge clk);
    chk(16'(msel), 16'hf);
    chk(16'(aaddr), haddr);
    $display("strobe wake done");
    cs_pin = 1'b1;
    ctl = 5'($random(seed));
    repeat (8) @(negedge clk);
    chk(16'(msel), 16'h0);
    chk(16'(lctl), 16'(ctl));
    run = 1'b0;
    wait_pd(1'b1, 600);
    cs_pin = 1'b0;
    wait_pd(1'b0, 40);
    $display("chip select wake done");
    wait_pd(1'b1, 600);
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    chk(16'(pd), 16'h1);
    rst_n = 1'b1;
    wait_pd(1'b0, 40);
    cfg = 1'b0;
    repeat (200) @(negedge clk);
    chk(16'(pd), 16'h0);
    chk(16'(icnt), 16'h0);
    chk(16'(rega), 16'h32);
    reset = 1'b1;
    @(negedge clk);
    reset = 1'b0;
    chk(16'(rega), 16'h0);
    $display("reset wake done");
    stop_test();
  end

  initial
  begin
    #(20 * 20000);
    miscompares++;
    stop_test();
  end
endmodule

// [verilog/apdc_pkg.sv]
// Constants and carrier types for the automatic power-down control block.
package apdc_pkg;

  localparam int IDLE_CNT_W = 4;
  localparam logic [IDLE_CNT_W-1:0] IDLE_LIMIT = 4'hf;
  localparam logic [IDLE_CNT_W-1:0] IDLE_CNT_RESET = 4'h0;

  localparam int REG_W = 8;
  localparam logic [REG_W-1:0] REG_A_RESET = 8'h00;
  localparam logic [REG_W-1:0] REG_C_RESET = 8'h00;
  localparam logic [REG_W-1:0] REG_A_USED_MASK = 8'h3a;
  localparam logic [REG_W-1:0] REG_C_USED_MASK = 8'h7c;

  localparam int A_APD_EN_BIT = 1;
  localparam int A_TURBO_OFF_BIT = 3;
  localparam int A_ARRAY_CLK_OFF_BIT = 4;
  localparam int A_MCELL_CLK_OFF_BIT = 5;
  localparam int C_CTL_BLOCK_LSB = 2;
  localparam int CTL_NUM = 5;

  localparam int PIN_STROBE = 0;
  localparam int PIN_CLOCK = 1;
  localparam int PIN_CS_N = 2;
  localparam int PIN_RESET_N = 3;
  localparam int PIN_NUM = 4;
  localparam logic [PIN_NUM-1:0] PIN_SYNC_RESET = 4'hc;

  typedef enum logic {APDC_RUN, APDC_DOWN} apdc_state_t;

  typedef struct packed {
    logic flash;
    logic eeprom;
    logic sram;
    logic io_space;
  } apdc_mem_t;

  typedef struct packed {
    logic data_port_oe;
    logic periph_oe;
    logic addr_out_valid;
  } apdc_pin_ctl_t;

endpackage

// [verilog/apdc_sync3.sv]
// Three-stage pin synchroniser that accepts a change once stages agree.
`timescale 1ns/1ps
module apdc_sync3 import apdc_pkg::*;
#(
  parameter int W = 4,
  parameter logic [W-1:0] INIT = '0
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_d;

  // A bit only moves when the last two stages agree, filtering one-cycle
  // metastable settling from reaching the counters.
  assign q_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & q);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      q <= INIT;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q <= q_d;
    end
  end

endmodule

// [verilog/apdc_top.sv]
// Automatic power-down control: idle timing, blocking and standby control.
`timescale 1ns/1ps
// How it works
// - Idle strobe starts four-bit logic-clock counter.
// - Fifteen idle logic clocks assert power-down.
// - Unit enable alone enables power-down entry.
// - Strobe activity wakes the device again.
// - Chip-select low or reset release wakes.
// - Power-down blocks host address/data, deselects memories.
// - Memories standby; logic and ports stay active.
// - Peripheral pins and data tri-stated, address undefined.
// - Clock blocking never stops the idle counter.
// - Power-down leaves logic behaviour to turbo only.
// - Turbo defaults on; set bit disables it.
// - Host-writable registers; blocking bits gate logic inputs.
// - Toggling unblocked inputs keep logic awake.
// - Chip-select high deselects all memories.
// - Chip-select blocks nothing in logic.
// - Port D pins give strobe and clock.
// - Memories wake on input change only.
// - Register A bit 1 enables the unit.
// - Register A bit 3 turns turbo off.
// - Register A bits 4,5 gate logic clock.
// - Registers clear at power-up reset only.
module apdc_top import apdc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic port_d_pin0,
  input wire logic port_d_pin1,
  input wire logic port_d_pin2,
  input wire logic reset_pin_n,
  input wire logic cfg_strobe_pin,
  input wire logic cfg_clock_pin,
  input wire logic cfg_cs_pin,
  input wire logic reg_a_wr,
  input wire logic reg_c_wr,
  input wire logic [REG_W-1:0] reg_wdata,
  input wire logic [15:0] host_addr,
  input wire logic [7:0] host_data,
  input wire logic [CTL_NUM-1:0] ctl_in,
  input wire logic data_port_oe_req,
  input wire logic periph_oe_req,
  input wire logic addr_out_req,
  output logic [REG_W-1:0] power_mode_reg_a_q,
  output logic [REG_W-1:0] power_mode_reg_c_q,
  output logic power_down_signal_q,
  output logic [IDLE_CNT_W-1:0] idle_count_q,
  output logic [15:0] arr_addr_q,
  output logic [7:0] arr_data_q,
  output apdc_mem_t mem_sel_q,
  output apdc_mem_t mem_standby_q,
  output apdc_pin_ctl_t pin_ctl_q,
  output logic [CTL_NUM-1:0] logic_ctl_q,
  output logic array_clk_q,
  output logic mcell_clk_q,
  output logic logic_turbo_q,
  output logic logic_standby_q
);

  // ******************************************************************
  // Pin synchronisation and edge detection
  // ******************************************************************
  logic [PIN_NUM-1:0] pins_raw;
  logic [PIN_NUM-1:0] pins_s;
  logic strobe_s;
  logic logic_clock_input_s;
  logic cs_n_s;
  logic rst_n_s;
  logic strobe_prev_q;
  logic logic_clock_input_prev_q;
  logic cs_prev_q;
  logic rst_prev_q;
  logic strobe_act;
  logic clk_rise;
  logic cs_fall;
  logic rst_rise;

  assign pins_raw = {reset_pin_n, port_d_pin2, port_d_pin1, port_d_pin0};
  apdc_sync3 #(
    .W(PIN_NUM),
    .INIT(PIN_SYNC_RESET)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .d(pins_raw),
    .q(pins_s)
  );

  // Unconfigured pins read as a quiet strobe, a still clock and a
  // selected chip, so the block falls back to plain always-on behaviour.
  assign strobe_s = cfg_strobe_pin & pins_s[PIN_STROBE];
  assign logic_clock_input_s = cfg_clock_pin & pins_s[PIN_CLOCK];
  assign cs_n_s = cfg_cs_pin & pins_s[PIN_CS_N];
  assign rst_n_s = pins_s[PIN_RESET_N];

  assign strobe_act = strobe_s ^ strobe_prev_q;
  assign clk_rise = logic_clock_input_s & ~logic_clock_input_prev_q;
  assign cs_fall = cs_prev_q & ~cs_n_s;
  assign rst_rise = rst_n_s & ~rst_prev_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      strobe_prev_q <= 1'b0;
      logic_clock_input_prev_q <= 1'b0;
      cs_prev_q <= 1'b0;
      rst_prev_q <= 1'b1;
    end
    else
    begin
      strobe_prev_q <= strobe_s;
      logic_clock_input_prev_q <= logic_clock_input_s;
      cs_prev_q <= cs_n_s;
      rst_prev_q <= rst_n_s;
    end
  end

  // ******************************************************************
  // Power mode registers
  // ******************************************************************
  logic apd_en;
  logic [CTL_NUM-1:0] ctl_block;

  // Only the power-up reset clears these; the device reset pin does not.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      power_mode_reg_a_q <= REG_A_RESET;
      power_mode_reg_c_q <= REG_C_RESET;
    end
    else
    begin
      if (reg_a_wr)
        power_mode_reg_a_q <= reg_wdata & REG_A_USED_MASK;
      if (reg_c_wr)
        power_mode_reg_c_q <= reg_wdata & REG_C_USED_MASK;
    end
  end

  assign apd_en = power_mode_reg_a_q[A_APD_EN_BIT];
  assign ctl_block = power_mode_reg_c_q[C_CTL_BLOCK_LSB +: CTL_NUM];

  // ******************************************************************
  // Idle counter and power-down state
  // ******************************************************************
  apdc_state_t state_q;
  apdc_state_t state_d;
  logic [IDLE_CNT_W-1:0] idle_count_d;
  logic idle_full;
  logic enter_down;
  logic wake;
  logic pd_next;

  assign idle_full = idle_count_q == IDLE_LIMIT;
  // The unit enable is the only gate on entry; no second mode enable.
  assign enter_down = apd_en & idle_full & ~strobe_act;
  assign wake = strobe_act | cs_fall | rst_rise | ~apd_en;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      APDC_RUN:
        if (enter_down)
          state_d = APDC_DOWN;
      APDC_DOWN:
        if (wake)
          state_d = APDC_RUN;
      default:
        state_d = APDC_RUN;
    endcase
  end
  assign pd_next = state_d == APDC_DOWN;

  // The counter sees the logic clock even when the arrays do not.
  always_comb
  begin
    idle_count_d = idle_count_q;
    if (~apd_en || strobe_act || state_q == APDC_DOWN)
      idle_count_d = IDLE_CNT_RESET;
    else if (clk_rise && !idle_full)
      idle_count_d = idle_count_q + 4'h1;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= APDC_RUN;
      idle_count_q <= IDLE_CNT_RESET;
      power_down_signal_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      idle_count_q <= idle_count_d;
      power_down_signal_q <= pd_next;
    end
  end

  // ******************************************************************
  // Host path blocking, memory select and standby
  // ******************************************************************
  logic host_changed;
  logic mem_on;
  apdc_mem_t mem_sel_d;
  apdc_mem_t mem_standby_d;
  apdc_pin_ctl_t pin_ctl_d;

  assign host_changed = (host_addr != arr_addr_q) | (host_data != arr_data_q);
  // Chip select deselects memories and its falling edge wakes power-down; logic paths ignore it.
  assign mem_on = ~pd_next & ~cs_n_s;
  assign mem_sel_d = {4{mem_on}};
  // A selected memory idles unless its frozen inputs are about to move.
  assign mem_standby_d = {4{~mem_on | ~host_changed}};
  assign pin_ctl_d.data_port_oe = data_port_oe_req & ~pd_next;
  assign pin_ctl_d.periph_oe = periph_oe_req & ~pd_next;
  assign pin_ctl_d.addr_out_valid = addr_out_req & ~pd_next;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      arr_addr_q <= 16'h0000;
      arr_data_q <= 8'h00;
      mem_sel_q <= '0;
      mem_standby_q <= '1;
      pin_ctl_q <= '0;
    end
    else
    begin
      if (!pd_next)
      begin
        arr_addr_q <= host_addr;
        arr_data_q <= host_data;
      end
      mem_sel_q <= mem_sel_d;
      mem_standby_q <= mem_standby_d;
      pin_ctl_q <= pin_ctl_d;
    end
  end

  // ******************************************************************
  // Logic array inputs, clocks and turbo
  // ******************************************************************
  logic [CTL_NUM-1:0] logic_ctl_d;
  logic array_clk_d;
  logic logic_toggling;

  // A blocked input holds its last level so it stops drawing switching
  // power; power-down itself never touches these paths.
  genvar gi;
  generate
    for (gi = 0; gi < CTL_NUM; gi++)
    begin : g_ctl
      assign logic_ctl_d[gi] = ctl_block[gi] ? logic_ctl_q[gi] : ctl_in[gi];
    end
  endgenerate

  assign array_clk_d = logic_clock_input_s & ~power_mode_reg_a_q[A_ARRAY_CLK_OFF_BIT];
  assign logic_toggling = (|(logic_ctl_d ^ logic_ctl_q)) |
                          (array_clk_d ^ array_clk_q) |
                          (~pd_next & host_changed);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      logic_ctl_q <= '0;
      array_clk_q <= 1'b0;
      mcell_clk_q <= 1'b0;
      logic_turbo_q <= 1'b1;
      logic_standby_q <= 1'b0;
    end
    else
    begin
      logic_ctl_q <= logic_ctl_d;
      array_clk_q <= array_clk_d;
      mcell_clk_q <= logic_clock_input_s & ~power_mode_reg_a_q[A_MCELL_CLK_OFF_BIT];
      logic_turbo_q <= ~power_mode_reg_a_q[A_TURBO_OFF_BIT];
      logic_standby_q <= power_mode_reg_a_q[A_TURBO_OFF_BIT] &
                         ~logic_toggling;
    end
  end

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_idle_full;
    state_q == APDC_RUN && apd_en && idle_full && !strobe_act;
  endsequence
  sequence s_enter_down;
    power_down_signal_q ##1 idle_count_q == IDLE_CNT_RESET;
  endsequence
  a_idle_count_step: assert property (
    (state_q == APDC_RUN && apd_en && !strobe_act && clk_rise &&
     idle_count_q < IDLE_LIMIT) |=> idle_count_q == $past(idle_count_q) + 4'h1)
    else $error("Idle counter did not advance on logic clock.");
  a_idle_entry: assert property (
    s_idle_full |=> s_enter_down)
    else $error("Power-down not entered after fifteen idle clocks.");
  a_disabled_no_down: assert property (
    !apd_en |=> !power_down_signal_q && idle_count_q == IDLE_CNT_RESET)
    else $error("Power-down active while the unit is disabled.");
  a_strobe_wakes: assert property (
    (state_q == APDC_DOWN && strobe_act) |=>
      !power_down_signal_q && idle_count_q == IDLE_CNT_RESET)
    else $error("Strobe activity did not wake the device.");
  a_cs_reset_wake: assert property (
    (state_q == APDC_DOWN && (cs_fall || rst_rise)) |=> !power_down_signal_q)
    else $error("Chip select or reset release did not wake.");
  a_host_blocked: assert property (
    power_down_signal_q && $past(power_down_signal_q) |->
      $stable(arr_addr_q) && $stable(arr_data_q))
    else $error("Host path moved during power-down.");
  a_mem_deselect: assert property (
    (power_down_signal_q || $past(cs_n_s)) |-> mem_sel_q == '0)
    else $error("Memory selected during power-down or chip deselect.");
  a_pins_tristate: assert property (
    power_down_signal_q |-> !pin_ctl_q.data_port_oe && !pin_ctl_q.periph_oe)
    else $error("Data or peripheral pins driven during power-down.");
  a_turbo_follow: assert property (
    $changed(power_mode_reg_a_q[A_TURBO_OFF_BIT]) |=>
      logic_turbo_q != $past(power_mode_reg_a_q[A_TURBO_OFF_BIT]))
    else $error("Turbo output does not follow register bit.");
  a_ctl_blocked: assert property (
    ctl_block[0] && $past(ctl_block[0]) |-> $stable(logic_ctl_q[0]))
    else $error("Blocked control input reached the logic arrays.");

endmodule
